// ==== verilog/urx_pkg.sv ====
// Package for the serial receive buffer block: register map, fields, states, records.
// Assumes a single 100 MHz clock and a plain strobe register port.
package urx_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [2:0] URX_ADDR_DATA   = 3'h0; // serial_data_buffer
    localparam logic [2:0] URX_ADDR_STATUS = 3'h1; // line_status_reg
    localparam logic [2:0] URX_ADDR_CTRLB  = 3'h2; // line_control_b_reg
    localparam logic [2:0] URX_ADDR_FORMAT = 3'h3; // frame_format_reg
    localparam logic [2:0] URX_ADDR_BAUD   = 3'h4; // baud divisor low byte only; high byte held at zero

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int URX_ST_RXC   = 7; // receive complete
    localparam int URX_ST_FE    = 4;
    localparam int URX_ST_DOR   = 3;
    localparam int URX_ST_UPE   = 2;
    localparam int URX_CB_RX_COMPLETE_IRQ_ENABLE = 7;
    localparam int URX_CB_RECEIVER_ENABLE_BIT  = 4;
    localparam int URX_CB_SZ2   = 2;
    localparam int URX_CB_RX9   = 1;
    localparam int URX_FF_SYNC  = 6; // external synchronous clock mode
    localparam int URX_FF_PEN   = 5; // parity_enable_bit
    localparam int URX_FF_PODD  = 4; // parity_odd_select
    localparam int URX_FF_SBS   = 3; // stop_bit_select, no effect on receive
    localparam int URX_FF_SZ1   = 2;
    localparam int URX_FF_SZ0   = 1;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [7:0]  URX_CTRLB_RST  = 8'h00;
    localparam logic [7:0]  URX_FORMAT_RST = 8'h06; // eight data bits
    localparam logic [15:0] URX_BAUD_RST   = 16'h0000;
    localparam logic [2:0]  URX_SZ_NINE    = 3'h7;
    localparam logic [3:0]  URX_OVS_MID    = 4'h7; // mid-bit sample of 16
    localparam logic [1:0]  URX_DEPTH      = 2'h2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        URX_IDLE  = 2'b00,
        URX_START = 2'b01,
        URX_BITS  = 2'b10,
        URX_STOP  = 2'b11
    } urx_state_t;

    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       overrun_flag;
        logic       parity_error_flag;
    } urx_entry_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } urx_bus_t;

endpackage

// ==== verilog/urx_receiver.sv ====
// Receive path of a serial port: framing, parity check, two-entry buffer, registers.
// Assumes rx_pin and sync_clk_pin are synchronous to sys_clk; the bus master never waits.
`timescale 1ns/1ps
`default_nettype none

module urx_receiver
    import urx_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    input  wire logic       rx_pin,
    input  wire logic       sync_clk_pin,
    input  wire logic       global_irq_en,
    output var  logic       rx_pin_override,
    output var  logic       rx_irq
);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        urx_state_t    st;
        logic [3:0]    ovs;
        logic [15:0]   bdiv;
        logic [3:0]    nbit;
        logic [9:0]    shf;
        logic          held;      // finished frame waiting in held_ent
        urx_entry_t    held_ent;
        urx_entry_t    e0;
        urx_entry_t    e1;
        logic [1:0]    cnt;
        logic          lost;      // overrun pending for next stored frame
        logic          rx_prev;
        logic          xck_prev;
        logic [7:0]    ctrlb;
        logic [7:0]    fmt;
        logic [15:0]   baud;
        logic [7:0]    rdata;
        logic          ovr;
        logic          irq;
    } urx_regs_t;

    urx_regs_t s_q;
    urx_regs_t s_d;
    urx_bus_t  bus;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic [3:0] urx_nbits(input logic [2:0] sz, input logic pen);
        logic [3:0] n;
        n = (sz == URX_SZ_NINE) ? 4'h9 : (sz[2] ? 4'h8 : 4'(5 + sz[1:0]));
        urx_nbits = n + {3'h0, pen};
    endfunction

    function automatic logic [8:0] urx_mask(input logic [2:0] sz);
        urx_mask = (sz == URX_SZ_NINE) ? 9'h1FF :
                   sz[2] ? 9'h0FF : 9'((9'h1 << (5 + sz[1:0])) - 9'h1);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    logic [2:0] sz;
    logic       en;
    logic       tick;
    logic       start_edge;
    logic       pop;
    logic       push;
    logic [3:0] ndat;
    logic [8:0] dat;
    logic       par_bit;
    urx_entry_t ne;

    always_comb begin
        s_d        = s_q;
        sz         = {s_q.ctrlb[URX_CB_SZ2], s_q.fmt[URX_FF_SZ1], s_q.fmt[URX_FF_SZ0]};
        en         = s_q.ctrlb[URX_CB_RECEIVER_ENABLE_BIT];
        ndat       = urx_nbits(sz, 1'b0);
        dat        = '0;
        par_bit    = 1'b0;
        ne         = '0;
        push       = 1'b0;
        pop        = bus.rd && bus.addr == URX_ADDR_DATA && s_q.cnt != 2'h0;
        start_edge = s_q.rx_prev && !rx_pin;
        s_d.rx_prev  = rx_pin;
        s_d.xck_prev = sync_clk_pin;
        // Sync mode samples on a rising pin edge; async uses the divided baud tick
        if (s_q.fmt[URX_FF_SYNC]) begin
            tick = sync_clk_pin && !s_q.xck_prev;
        end else begin
            tick = s_q.bdiv == s_q.baud;
        end
        s_d.bdiv = tick ? 16'h0000 : s_q.bdiv + 16'h0001;

        // Receiver framing
        case (s_q.st)
            URX_IDLE: begin
                s_d.ovs = 4'h0;
                if (start_edge) begin
                    s_d.st = s_q.fmt[URX_FF_SYNC] ? URX_BITS : URX_START;
                    s_d.nbit = 4'h0;
                    s_d.bdiv = 16'h0000;
                    // Overrun: full buffer, frame held, new start seen
                    if (s_q.cnt == URX_DEPTH && s_q.held) begin
                        s_d.lost = 1'b1;
                    end
                end
            end
            URX_START: begin
                if (tick) begin
                    s_d.ovs = s_q.ovs + 4'h1;
                    if (s_q.ovs == URX_OVS_MID) begin
                        s_d.ovs = 4'h0;
                        // A glitch that is high at mid-bit is not a start
                        s_d.st = rx_pin ? URX_IDLE : URX_BITS;
                    end
                end
            end
            URX_BITS: begin
                if (tick) begin
                    s_d.ovs = s_q.ovs + 4'h1;
                    if (s_q.ovs == 4'hF || s_q.fmt[URX_FF_SYNC]) begin
                        s_d.ovs  = 4'h0;
                        s_d.shf  = {rx_pin, s_q.shf[9:1]};
                        s_d.nbit = s_q.nbit + 4'h1;
                        if (s_q.nbit + 4'h1 == urx_nbits(sz, s_q.fmt[URX_FF_PEN])) begin
                            s_d.st = URX_STOP;
                        end
                    end
                end
            end
            URX_STOP: begin
                if (tick) begin
                    s_d.ovs = s_q.ovs + 4'h1;
                    if (s_q.ovs == 4'hF || s_q.fmt[URX_FF_SYNC]) begin
                        // Second stop bit never sampled; back to idle
                        s_d.st = URX_IDLE;
                        s_d.shf = s_q.shf >> (4'hA - urx_nbits(sz, s_q.fmt[URX_FF_PEN]));
                        dat = (s_d.shf[8:0]) & urx_mask(sz);
                        par_bit = s_d.shf[ndat];
                        ne.data = dat;
                        ne.fe   = !rx_pin;
                        // Even when odd select is zero
                        ne.parity_error_flag  = s_q.fmt[URX_FF_PEN] &&
                                  ((^dat) ^ par_bit ^ s_q.fmt[URX_FF_PODD]);
                        s_d.held     = 1'b1;
                        s_d.held_ent = ne;
                    end
                end
            end
            default: s_d.st = URX_IDLE;
        endcase

        // Buffer pop: entries carry flags and ninth bit with them
        if (pop) begin
            s_d.e0  = s_q.e1;
            s_d.cnt = s_q.cnt - 2'h1;
        end
        // Held frame moves in as soon as there is room
        if (s_q.held && (s_d.cnt != URX_DEPTH)) begin
            ne     = s_q.held_ent;
            ne.overrun_flag = s_q.lost;
            if (s_d.cnt == 2'h0) begin
                s_d.e0 = ne;
            end else begin
                s_d.e1 = ne;
            end
            s_d.cnt  = s_d.cnt + 2'h1;
            s_d.lost = 1'b0;
            push     = 1'b1;
            if (!(s_q.st == URX_STOP && s_d.st == URX_IDLE)) begin
                s_d.held = 1'b0;
            end
        end

        // Register writes; status is read-only so flags cannot be altered
        if (bus.wr) begin
            if (bus.addr == URX_ADDR_CTRLB) begin
                s_d.ctrlb = bus.wdata;
            end else if (bus.addr == URX_ADDR_FORMAT) begin
                s_d.fmt = bus.wdata;
            end else if (bus.addr == URX_ADDR_BAUD) begin
                s_d.baud = {8'h00, bus.wdata};
            end
        end

        // Disable is immediate: frame dropped, buffer flushed
        if (!s_d.ctrlb[URX_CB_RECEIVER_ENABLE_BIT]) begin
            s_d.st   = URX_IDLE;
            s_d.held = 1'b0;
            s_d.lost = 1'b0;
            s_d.cnt  = 2'h0;
        end

        // Read data, one cycle after the strobe
        s_d.rdata = 8'h00;
        if (bus.rd) begin
            if (bus.addr == URX_ADDR_DATA) begin
                s_d.rdata = s_q.e0.data[7:0];
            end else if (bus.addr == URX_ADDR_STATUS) begin
                s_d.rdata[URX_ST_RXC] = s_q.cnt != 2'h0;
                s_d.rdata[URX_ST_FE]  = s_q.cnt != 2'h0 && s_q.e0.fe;
                s_d.rdata[URX_ST_DOR] = s_q.cnt != 2'h0 && s_q.e0.overrun_flag;
                s_d.rdata[URX_ST_UPE] = s_q.cnt != 2'h0 && s_q.e0.parity_error_flag;
            end else if (bus.addr == URX_ADDR_CTRLB) begin
                s_d.rdata = s_q.ctrlb;
                s_d.rdata[URX_CB_RX9] = s_q.cnt != 2'h0 && s_q.e0.data[8];
            end else if (bus.addr == URX_ADDR_FORMAT) begin
                s_d.rdata = s_q.fmt;
            end else if (bus.addr == URX_ADDR_BAUD) begin
                s_d.rdata = s_q.baud[7:0];
            end
        end
        s_d.ovr = s_d.ctrlb[URX_CB_RECEIVER_ENABLE_BIT];
        // Only the buffer level drives the request, never the error flags
        s_d.irq = s_d.ctrlb[URX_CB_RX_COMPLETE_IRQ_ENABLE] && global_irq_en && s_d.cnt != 2'h0;
        if (!en) begin
            s_d.bdiv = 16'h0000;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q       <= '0;
            s_q.st    <= URX_IDLE;
            s_q.ctrlb <= URX_CTRLB_RST;
            s_q.fmt   <= URX_FORMAT_RST;
            s_q.baud  <= URX_BAUD_RST;
            s_q.rx_prev  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata       = s_q.rdata;
    assign rx_pin_override = s_q.ovr;
    assign rx_irq          = s_q.irq;

    // ****************************************************************
    // Check helpers
    // ****************************************************************
    // Edge at which the first stop bit is taken and the frame is latched
    logic stop_take;

    assign stop_take = s_q.st == URX_STOP && tick &&
                       (s_q.ovs == 4'hF || s_q.fmt[URX_FF_SYNC]);

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_disable_flush: assert property (@(posedge sys_clk) disable iff (rst)
        !s_q.ctrlb[URX_CB_RECEIVER_ENABLE_BIT] |=> s_q.cnt == 2'h0 || s_q.ctrlb[URX_CB_RECEIVER_ENABLE_BIT])
        else $error("buffer not flushed while disabled");
    a_disable_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !s_q.ctrlb[URX_CB_RECEIVER_ENABLE_BIT] |-> s_q.st == URX_IDLE || $past(s_q.ctrlb[URX_CB_RECEIVER_ENABLE_BIT]))
        else $error("frame continued after disable");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
        rx_irq == (s_q.ctrlb[URX_CB_RX_COMPLETE_IRQ_ENABLE] && $past(global_irq_en) &&
                   s_q.cnt != 2'h0))
        else $error("interrupt does not follow buffer level");
    a_rxc_read: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == URX_ADDR_STATUS |=> reg_rdata[URX_ST_RXC] == ($past(s_q.cnt) != 2'h0))
        else $error("receive complete wrong");
    a_pop_advance: assert property (@(posedge sys_clk) disable iff (rst)
        pop && s_q.cnt == 2'h2 && !push && s_q.ctrlb[URX_CB_RECEIVER_ENABLE_BIT] |=> s_q.cnt == 2'h1 &&
        s_q.e0 == $past(s_q.e1))
        else $error("read did not advance buffer");
    a_upe_off: assert property (@(posedge sys_clk) disable iff (rst)
        stop_take && !s_q.fmt[URX_FF_PEN] |=> !s_q.held_ent.parity_error_flag)
        else $error("parity flag set with checking off");
    a_over_clear: assert property (@(posedge sys_clk) disable iff (rst)
        push |=> !s_q.lost || $past(start_edge))
        else $error("overrun not cleared on transfer");
    a_depth_max: assert property (@(posedge sys_clk) disable iff (rst)
        s_q.cnt <= URX_DEPTH)
        else $error("buffer over depth");
    a_pin_own: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 rx_pin_override == $past(s_d.ctrlb[URX_CB_RECEIVER_ENABLE_BIT]))
        else $error("pin override wrong");

    // ****************************************************************
    // Frame checks
    // ****************************************************************
    // Frame error and unused upper data bits are checked as they are latched, before buffering
    a_fe_stop: assert property (@(posedge sys_clk) disable iff (rst)
        stop_take |=> s_q.held_ent.fe == !$past(rx_pin))
        else $error("frame error does not match first stop bit");
    a_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
        stop_take |=> (s_q.held_ent.data & ~urx_mask($past(sz))) == 9'h000)
        else $error("unused upper data bits not zero");
    a_held_push: assert property (@(posedge sys_clk) disable iff (rst)
        s_q.held && s_q.cnt != URX_DEPTH |-> push)
        else $error("finished frame not moved into buffer");
    a_status_ro: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == URX_ADDR_STATUS && !push && !pop |=> s_q.e0 == $past(s_q.e0))
        else $error("status write altered buffered flags");
    a_sync_tick: assert property (@(posedge sys_clk) disable iff (rst)
        s_q.fmt[URX_FF_SYNC] && s_q.st == URX_BITS && !(sync_clk_pin && !s_q.xck_prev)
        |=> s_q.nbit == $past(s_q.nbit))
        else $error("sync bit taken without a clock edge");
    a_err_noirq: assert property (@(posedge sys_clk) disable iff (rst)
        rx_irq |-> s_q.cnt != 2'h0 && s_q.ctrlb[URX_CB_RX_COMPLETE_IRQ_ENABLE])
        else $error("interrupt without buffered data");

    c_frame_in: cover property (@(posedge sys_clk) disable iff (rst) push);
    c_full: cover property (@(posedge sys_clk) disable iff (rst) s_q.cnt == 2'h2 && s_q.held);
    c_overrun: cover property (@(posedge sys_clk) disable iff (rst) s_q.lost ##1 push);
    c_sync_frame: cover property (@(posedge sys_clk) disable iff (rst)
        push && s_q.fmt[URX_FF_SYNC]);
    c_parity_bad: cover property (@(posedge sys_clk) disable iff (rst)
        push && s_q.held_ent.parity_error_flag);

endmodule

`default_nettype wire

// ==== testbench/urx_tx_model.sv ====
// Remote serial transmitter model driving the receive line of the block.
// Assumes a divisor of 0, so one bit lasts 16 clocks of sys_clk.
// A sync clock pulse rises mid-bit for every bit after start, and rests low otherwise.
`timescale 1ns/1ps
`default_nettype none
module urx_tx_model (
    input  wire logic        sys_clk,
    input  wire logic        send,
    input  wire logic [11:0] bits,
    input  wire logic [3:0]  len,
    output var  logic        busy,
    output var  logic        line,
    output var  logic        sclk
);
    // ****************************************************************
    // Frame generator
    // ****************************************************************
    // The line idles high between frames; len counts every bit after start
    initial begin
        line = 1'b1;
        busy = 1'b0;
        sclk = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (send) begin
                busy <= 1'b1;
                line <= 1'b0;
                repeat (16) @(posedge sys_clk);
                for (int i = 0; i < int'(len); i++) begin
                    line <= bits[i];
                    repeat (8) @(posedge sys_clk);
                    sclk <= 1'b1;
                    repeat (8) @(posedge sys_clk);
                    sclk <= 1'b0;
                end
                line <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_urx_receiver.sv ====
// Testbench for the serial receive block: register tasks and frame scenarios.
// Assumes a divisor of 0 (16 clocks a bit) and the transmitter model beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb_urx_receiver import urx_pkg::*;;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        rx_pin;
    logic        glb_en = 1'b0;
    logic        override;
    logic        irq;
    logic        send = 1'b0;
    logic [11:0] tx_bits = 12'h000;
    logic [3:0]  tx_len = 4'h0;
    logic        tx_busy;
    logic        sclk;
    int          num_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [7:0]  pf [3] = '{8'h26, 8'h26, 8'h36};
    logic [11:0] pb [3] = '{12'h203, 12'h303, 12'h303};
    logic [7:0]  ps [3] = '{8'h80, 8'h84, 8'h80};

    always #5 sys_clk = ~sys_clk;

    // Sync clock comes from the transmitter; it only counts while format bit 6 is set
    urx_receiver uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_pin(rx_pin), .sync_clk_pin(sclk), .global_irq_en(glb_en),
        .rx_pin_override(override), .rx_irq(irq));
    urx_tx_model tx (.sys_clk(sys_clk), .send(send), .bits(tx_bits), .len(tx_len),
        .busy(tx_busy), .line(rx_pin), .sclk(sclk));

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        `CHK(reg_rdata, e)
    endtask

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic snd(input logic [11:0] b, input logic [3:0] l, input bit w);
        int n;
        @(posedge sys_clk);
        tx_bits <= b;
        tx_len <= l;
        send <= 1'b1;
        @(posedge sys_clk);
        send <= 1'b0;
        @(posedge sys_clk);
        n = 0;
        while (w && tx_busy && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        if (w) repeat (4) @(posedge sys_clk);
    endtask

    task automatic test_done();
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(URX_ADDR_CTRLB, URX_CTRLB_RST);
        rchk(URX_ADDR_FORMAT, URX_FORMAT_RST);
        rchk(3'h7, 8'h00);
        wr(URX_ADDR_CTRLB, 8'h10);
        settle();
        `CHK(override, 1'b1)
        snd(12'h1A5, 4'h9, 1);
        rchk(URX_ADDR_STATUS, 8'h80);
        rchk(URX_ADDR_DATA, 8'hA5);
        rchk(URX_ADDR_STATUS, 8'h00);
        // Second stop bit set while the first is low: only the first counts
        wr(URX_ADDR_FORMAT, 8'h0E);
        snd(12'h25A, 4'hA, 1);
        wr(URX_ADDR_STATUS, 8'hFF);
        rchk(URX_ADDR_STATUS, 8'h90);
        rchk(URX_ADDR_DATA, 8'h5A);
        wr(URX_ADDR_FORMAT, 8'h00);
        snd(12'h03F, 4'h6, 1);
        rchk(URX_ADDR_DATA, 8'h1F);
        wr(URX_ADDR_FORMAT, 8'h46);
        snd(12'h1C3, 4'h9, 1);
        rchk(URX_ADDR_DATA, 8'hC3);
        for (int i = 0; i < 3; i++) begin
            wr(URX_ADDR_FORMAT, pf[i]);
            snd(pb[i], 4'hA, 1);
            rchk(URX_ADDR_STATUS, ps[i]);
            rchk(URX_ADDR_DATA, 8'h03);
        end
        wr(URX_ADDR_FORMAT, 8'h06);
        wr(URX_ADDR_CTRLB, 8'h14);
        snd(12'h3A5, 4'hA, 1);
        rchk(URX_ADDR_CTRLB, 8'h16);
        rchk(URX_ADDR_DATA, 8'hA5);
        rchk(URX_ADDR_CTRLB, 8'h14);
        wr(URX_ADDR_CTRLB, 8'h90);
        glb_en <= 1'b1;
        // Two buffered, one held; the fourth start overruns and its frame replaces the held one
        snd(12'h111, 4'h9, 1);
        snd(12'h122, 4'h9, 1);
        snd(12'h133, 4'h9, 1);
        snd(12'h144, 4'h9, 1);
        settle();
        `CHK(irq, 1'b1)
        @(posedge sys_clk) glb_en <= 1'b0;
        settle();
        `CHK(irq, 1'b0)
        @(posedge sys_clk) glb_en <= 1'b1;
        rchk(URX_ADDR_STATUS, 8'h80);
        rchk(URX_ADDR_DATA, 8'h11);
        rchk(URX_ADDR_STATUS, 8'h80);
        rchk(URX_ADDR_DATA, 8'h22);
        rchk(URX_ADDR_STATUS, 8'h88);
        rchk(URX_ADDR_DATA, 8'h44);
        rchk(URX_ADDR_STATUS, 8'h00);
        settle();
        `CHK(irq, 1'b0)
        snd(12'h155, 4'h9, 1);
        rchk(URX_ADDR_STATUS, 8'h80);
        rchk(URX_ADDR_DATA, 8'h55);
        snd(12'h166, 4'h9, 1);
        // Disable mid-frame, re-enable after the last falling edge of it
        snd(12'h10F, 4'h9, 0);
        repeat (36) @(posedge sys_clk);
        wr(URX_ADDR_CTRLB, 8'h00);
        rchk(URX_ADDR_STATUS, 8'h00);
        `CHK(override, 1'b0)
        `CHK(irq, 1'b0)
        repeat (40) @(posedge sys_clk);
        wr(URX_ADDR_CTRLB, 8'h10);
        repeat (120) @(posedge sys_clk);
        rchk(URX_ADDR_STATUS, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
